// [access_check.sv]
`default_nettype none
// pure permission decision for one request
module access_check (
  // request and state
  input wire flash_access_pkg::flash_req_t req,
  input wire logic lower_half_protect_n,
  input wire logic full_rw_protect_n,
  input wire logic [7:0] flash_page_select,
  input wire logic [7:0] sector_protect_mask,
  // decision
  output logic allow
);
  logic [2:0] sect;
  logic prot_any;
  logic upper;
  logic page_ok;
  logic addr_ok;
  always_comb begin
    sect = req.addr[flash_access_pkg::SECT_ADDR_HI:flash_access_pkg::SECT_ADDR_LO];
    prot_any = !lower_half_protect_n || !full_rw_protect_n;
    upper = req.addr[flash_access_pkg::ADDR_MSB];
    page_ok = (flash_page_select == flash_access_pkg::INFO_PAGE_SEL);
    addr_ok = req.addr[flash_access_pkg::INFO_ADDR_HI:flash_access_pkg::INFO_ADDR_LO]
      == flash_page_select[flash_access_pkg::PAGE_SEL_HI:flash_access_pkg::PAGE_SEL_LO];
    allow = 1'b0;
    if (req.valid) begin
      unique case (req.src)
        flash_access_pkg::src_cpu: begin
          // protect bits ignored, sector mask applies to program and page erase only
          if (!req.info && req.op == flash_access_pkg::op_read) allow = 1'b1;
          else if (!req.info && req.op != flash_access_pkg::op_mass_erase)
            allow = !sector_protect_mask[sect];
          else allow = 1'b0;
        end
        default: begin
          if (req.op == flash_access_pkg::op_mass_erase) begin
            allow = !req.info;
          end else if (req.info) begin
            allow = page_ok;
            if (req.op == flash_access_pkg::op_program && !addr_ok) allow = 1'b0;
            if (req.op != flash_access_pkg::op_read && prot_any) allow = 1'b0;
          end else if (!full_rw_protect_n) begin
            allow = 1'b0;
          end else if (!lower_half_protect_n) begin
            allow = upper;
          end else begin
            allow = 1'b1;
          end
        end
      endcase
    end
  end
endmodule // access_check
`default_nettype wire

// [bypass_entry.sv]
`default_nettype none
// watches port bytes for the three-byte bypass entry sequence
module bypass_entry (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // byte stream from the programming port
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  // result
  output logic bypass_on
);
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_baud = 2'b01,
    st_cmd = 2'b10,
    st_on = 2'b11
  } entry_t;
  entry_t state_r;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= st_idle;
    end else if (clk_en && byte_valid) begin
      unique case (state_r)
        st_idle: state_r <= (byte_data == flash_access_pkg::BYP_AUTOBAUD) ? st_baud : st_idle;
        st_baud: state_r <= (byte_data == flash_access_pkg::BYP_TM_WRITE) ? st_cmd : st_idle;
        st_cmd: state_r <= (byte_data == flash_access_pkg::BYP_TM_DATA) ? st_on : st_idle;
        st_on: state_r <= st_on;
      endcase
    end
  end

  // sticky until reset, as the port leaves test mode only through power cycling
  assign bypass_on = (state_r == st_on);

  a_entry_order: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(bypass_on) |-> $past(byte_valid) && $past(byte_data) == flash_access_pkg::BYP_TM_DATA)
    else $error("bypass entered without data byte");
endmodule // bypass_entry
`default_nettype wire

// [flash_access_permission.sv]
// Design decisions made here: the plain strobed port and the register addresses.
`default_nettype none
// Notes on behaviour
// - lower-half protect blocks port lower half
// - full protect blocks port main memory
// - any protect blocks port info writes/erase
// - cpu ignores both protection bits
// - info area reachable at page three only
// - bypass drives flash from registered pins
// - bypass stops cpu clock and accesses
// - port and bypass mass erase allowed whatever the protection; cpu mass erase always refused
// - bypass unprotected: full main access
// - bypass full protect: only mass erase
// - bypass lower protect: upper half only
// - cpu info program/erase ignored
// - port info ops need page select 83h
// - info program needs address/page match
module flash_access_permission (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // option bits, active low
  input wire logic lower_half_protect_n,
  input wire logic full_rw_protect_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // cpu request
  input wire flash_access_pkg::flash_cmd_t cpu_req,
  // programming port request and raw bytes
  input wire flash_access_pkg::flash_cmd_t port_req,
  input wire logic port_byte_valid,
  input wire logic [7:0] port_byte,
  // bypass pins, asynchronous
  input wire flash_access_pkg::flash_cmd_t pin_req,
  // flash side
  output flash_access_pkg::flash_cmd_t flash_cmd,
  input wire logic [7:0] flash_rdata,
  // results
  output logic [7:0] rdata,
  output logic rdata_valid,
  output logic refused,
  output logic cpu_clk_stop,
  output logic bypass_active
);
  flash_access_pkg::flash_cmd_t pin_s1_r, pin_s2_r, pin_s3_r, pin_q_r;
  flash_access_pkg::flash_req_t sel_req;
  logic [7:0] page_sel_r;
  logic [7:0] sector_r;
  logic bypass_on;
  logic allow;
  logic pend_read_r;
  logic pend_ok_r;

  bypass_entry u_entry (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .byte_valid(port_byte_valid),
    .byte_data(port_byte),
    .bypass_on(bypass_on)
  );

  // pins pass three stages; a change counts when the last two agree
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
      pin_q_r <= '0;
    end else if (clk_en) begin
      pin_s1_r <= pin_req;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      if (pin_s2_r == pin_s3_r) pin_q_r <= pin_s3_r;
    end
  end

  // page select and sector mask; sector bits only set until reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      page_sel_r <= flash_access_pkg::RESET_BYTE;
      sector_r <= flash_access_pkg::RESET_BYTE;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == flash_access_pkg::REG_PAGE_SEL) page_sel_r <= reg_wdata;
      if (reg_addr == flash_access_pkg::REG_SECTOR) sector_r <= sector_r | reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= flash_access_pkg::RESET_BYTE;
    end else if (clk_en) begin
      if (!reg_rd) reg_rdata <= flash_access_pkg::RESET_BYTE;
      else begin
        unique case (reg_addr)
          flash_access_pkg::REG_PAGE_SEL: reg_rdata <= page_sel_r;
          flash_access_pkg::REG_SECTOR: reg_rdata <= sector_r;
          flash_access_pkg::REG_OPTION:
            reg_rdata <= {6'h00, full_rw_protect_n, lower_half_protect_n};
          flash_access_pkg::REG_STATUS: reg_rdata <= {6'h00, refused, bypass_active};
          default: reg_rdata <= flash_access_pkg::RESET_BYTE;
        endcase
      end
    end
  end

  // bypass overrides everything; otherwise the port wins over the cpu
  always_comb begin
    sel_req = '0;
    if (bypass_on) begin
      sel_req = {pin_q_r.valid, flash_access_pkg::src_bypass, pin_q_r.op, pin_q_r.info,
        pin_q_r.addr, pin_q_r.wdata};
    end else if (port_req.valid) begin
      sel_req = {port_req.valid, flash_access_pkg::src_port, port_req.op, port_req.info,
        port_req.addr, port_req.wdata};
    end else begin
      sel_req = {cpu_req.valid, flash_access_pkg::src_cpu, cpu_req.op, cpu_req.info,
        cpu_req.addr, cpu_req.wdata};
    end
  end

  access_check u_check (
    .req(sel_req),
    .lower_half_protect_n(lower_half_protect_n),
    .full_rw_protect_n(full_rw_protect_n),
    .flash_page_select(page_sel_r),
    .sector_protect_mask(sector_r),
    .allow(allow)
  );

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flash_cmd <= '0;
      refused <= 1'b0;
      pend_read_r <= 1'b0;
      pend_ok_r <= 1'b0;
    end else if (clk_en) begin
      // refused requests never reach the flash
      flash_cmd <= allow ? {sel_req.valid, sel_req.op, sel_req.info, sel_req.addr,
        sel_req.wdata} : '0;
      refused <= sel_req.valid && !allow;
      pend_read_r <= sel_req.valid && sel_req.op == flash_access_pkg::op_read;
      pend_ok_r <= allow;
    end
  end

  // read data one cycle after the flash command; zero when refused
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= flash_access_pkg::RESET_BYTE;
      rdata_valid <= 1'b0;
    end else if (clk_en) begin
      rdata_valid <= pend_read_r;
      rdata <= (pend_read_r && pend_ok_r) ? flash_rdata : flash_access_pkg::RESET_BYTE;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cpu_clk_stop <= 1'b0;
      bypass_active <= 1'b0;
    end else if (clk_en) begin
      cpu_clk_stop <= bypass_on;
      bypass_active <= bypass_on;
    end
  end

  a_refused_no_cmd: assert property (@(posedge sys_clk) disable iff (!resetn)
    refused |-> !flash_cmd.valid)
    else $error("refused request reached flash");
  a_full_prot_port: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && !bypass_on && port_req.valid && !full_rw_protect_n && !port_req.info &&
    port_req.op != flash_access_pkg::op_mass_erase |=> refused)
    else $error("full protect not enforced");
  a_lower_half: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && sel_req.src != flash_access_pkg::src_cpu && !lower_half_protect_n &&
    !sel_req.info && !sel_req.addr[flash_access_pkg::ADDR_MSB] && sel_req.valid &&
    sel_req.op != flash_access_pkg::op_mass_erase |=> refused)
    else $error("lower half protect not enforced");
  a_info_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && sel_req.valid && sel_req.info && sel_req.src != flash_access_pkg::src_cpu &&
    sel_req.op != flash_access_pkg::op_read && (!lower_half_protect_n || !full_rw_protect_n)
    |=> refused)
    else $error("info write under protection");
  a_cpu_ignores: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && !bypass_on && !port_req.valid && cpu_req.valid && !cpu_req.info &&
    cpu_req.op == flash_access_pkg::op_read |=> flash_cmd.valid)
    else $error("cpu read refused");
  a_cpu_info: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && sel_req.src == flash_access_pkg::src_cpu && sel_req.valid &&
    (sel_req.info || sel_req.op == flash_access_pkg::op_mass_erase) |=> refused)
    else $error("cpu info or mass erase passed");
  a_info_page: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && sel_req.valid && sel_req.info && sel_req.src != flash_access_pkg::src_cpu &&
    page_sel_r != flash_access_pkg::INFO_PAGE_SEL |=> refused)
    else $error("info access off page three");
  a_info_addr: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && allow && sel_req.info && sel_req.op == flash_access_pkg::op_program |->
    sel_req.addr[flash_access_pkg::INFO_ADDR_HI:flash_access_pkg::INFO_ADDR_LO] ==
    page_sel_r[flash_access_pkg::PAGE_SEL_HI:flash_access_pkg::PAGE_SEL_LO])
    else $error("info program address mismatch");
  a_mass_erase: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && sel_req.valid && sel_req.src != flash_access_pkg::src_cpu && !sel_req.info &&
    sel_req.op == flash_access_pkg::op_mass_erase |=> flash_cmd.valid)
    else $error("mass erase refused");
  a_bypass_full: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && bypass_on && full_rw_protect_n && lower_half_protect_n && sel_req.valid &&
    !sel_req.info |=> flash_cmd.valid)
    else $error("unprotected bypass refused");
  a_clk_stop: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && bypass_on |=> cpu_clk_stop)
    else $error("cpu clock not stopped");
  a_sector_port: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && !bypass_on && port_req.valid && !port_req.info && full_rw_protect_n &&
    lower_half_protect_n && port_req.op != flash_access_pkg::op_read |=> flash_cmd.valid)
    else $error("sector mask applied to port");
endmodule // flash_access_permission
`default_nettype wire

// [flash_access_pkg.sv]
`default_nettype none
package flash_access_pkg;
  localparam int ADDR_W = 16;
  localparam int ADDR_MSB = 15;
  localparam logic [7:0] BYP_AUTOBAUD = 8'h80;
  localparam logic [7:0] BYP_TM_WRITE = 8'hf0;
  localparam logic [7:0] BYP_TM_DATA = 8'h04;
  localparam logic [7:0] INFO_PAGE_SEL = 8'h83;
  localparam int INFO_ADDR_HI = 12;
  localparam int INFO_ADDR_LO = 6;
  localparam int PAGE_SEL_HI = 6;
  localparam int PAGE_SEL_LO = 0;
  localparam int PAGE_SEL_EN = 7;
  localparam int SECT_ADDR_HI = 15;
  localparam int SECT_ADDR_LO = 13;
  localparam logic [7:0] REG_PAGE_SEL = 8'h00;
  localparam logic [7:0] REG_SECTOR = 8'h04;
  localparam logic [7:0] REG_OPTION = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef enum logic [1:0] {
    src_cpu = 2'b00,
    src_port = 2'b01,
    src_bypass = 2'b10
  } src_t;

  typedef enum logic [1:0] {
    op_program = 2'b00,
    op_read = 2'b01,
    op_page_erase = 2'b10,
    op_mass_erase = 2'b11
  } op_t;

  typedef struct packed {
    logic valid;
    src_t src;
    op_t op;
    logic info;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } flash_req_t;

  typedef struct packed {
    logic valid;
    op_t op;
    logic info;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } flash_cmd_t;
endpackage
`default_nettype wire

// [serial_programmer.sv]
`default_nettype none
// stands in for the external programmer on the serial programming port
module serial_programmer (
  // clock
  input wire logic sys_clk,
  // port side
  output flash_access_pkg::flash_cmd_t port_req,
  output logic port_byte_valid,
  output logic [7:0] port_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    port_req = '0;
    port_byte_valid = 1'b0;
    port_byte = 8'h00;
  end
  // released lanes show the inverse so a stale value can never pass
  task automatic send3(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    logic [23:0] seq;
    seq = {b0, b1, b2};
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      port_byte_valid <= 1'b1;
      port_byte <= seq[23-8*i -: 8];
    end
    @(posedge sys_clk);
    port_byte_valid <= 1'b0;
    port_byte <= ~seq[7:0];
  endtask
  task automatic issue(input flash_access_pkg::flash_cmd_t c);
    flash_access_pkg::flash_cmd_t r;
    r = ~c;
    r.valid = 1'b0;
    @(posedge sys_clk);
    port_req <= c;
    @(posedge sys_clk);
    port_req <= r;
  endtask
endmodule // serial_programmer
`default_nettype wire

// [test_flash_access_permission.sv]
`default_nettype none
module test_flash_access_permission;
  timeunit 1ns;
  timeprecision 1ns;
  localparam flash_access_pkg::op_t o_pr = flash_access_pkg::op_program;
  localparam flash_access_pkg::op_t o_rd = flash_access_pkg::op_read;
  localparam flash_access_pkg::op_t o_pe = flash_access_pkg::op_page_erase;
  localparam flash_access_pkg::op_t o_me = flash_access_pkg::op_mass_erase;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic lower_half_protect_n = 1'b1;
  logic full_rw_protect_n = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  flash_access_pkg::flash_cmd_t cpu_req = '0;
  flash_access_pkg::flash_cmd_t pin_req = '0;
  flash_access_pkg::flash_cmd_t port_req;
  flash_access_pkg::flash_cmd_t flash_cmd;
  logic port_byte_valid;
  logic [7:0] port_byte;
  logic [7:0] flash_rdata = 8'ha5;
  logic [7:0] rdata;
  logic rdata_valid;
  logic refused;
  logic cpu_clk_stop;
  logic bypass_active;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;

  always #50 sys_clk = ~sys_clk;

  flash_access_permission DUT (.sys_clk, .resetn, .clk_en, .lower_half_protect_n,
    .full_rw_protect_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_req,
    .port_req, .port_byte_valid, .port_byte, .pin_req, .flash_cmd, .flash_rdata, .rdata,
    .rdata_valid, .refused, .cpu_clk_stop, .bypass_active);

  serial_programmer prog (.sys_clk, .port_req, .port_byte_valid, .port_byte);

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("[FAIL] %0t run did not finish", $time);
      close_out();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  function automatic flash_access_pkg::flash_cmd_t rel(input flash_access_pkg::flash_cmd_t c);
    rel = ~c;
    rel.valid = 1'b0;
  endfunction

  // src 0 cpu, 1 port, 2 pins; want 0 refused, 1 carried out, 2 no command at all
  task automatic access(input int src, input logic [1:0] prot, input flash_access_pkg::op_t op,
      input logic info, input logic [15:0] addr, input int want);
    flash_access_pkg::flash_cmd_t c;
    logic seen;
    int lat;
    c = {1'b1, op, info, addr, 8'h3c};
    seen = 1'b0;
    @(posedge sys_clk);
    lower_half_protect_n <= prot[1];
    full_rw_protect_n <= prot[0];
    if (src == 1) begin
      prog.issue(c);
    end else if (src == 0) begin
      cpu_req <= c;
      @(posedge sys_clk);
      cpu_req <= rel(c);
    end else begin
      pin_req <= c;
      // two cycles so the synchroniser stages agree once
      repeat (2) @(posedge sys_clk);
      pin_req <= rel(c);
    end
    for (lat = 0; lat < 8 && seen !== 1'b1; lat++) begin
      #1;
      seen = flash_cmd.valid === 1'b1 || (want != 2 && refused === 1'b1);
      if (seen !== 1'b1) @(posedge sys_clk);
    end
    check(seen, want != 2, "outcome");
    if (src < 2 && want != 2) check(lat, 1, "latency");
    if (want != 2) begin
      check(flash_cmd.valid, want, "command");
      check(refused, want == 0, "refused flag");
      if (want == 1) check(flash_cmd, c, "command fields");
      if (op == o_rd) begin
        @(posedge sys_clk);
        #1;
        check(rdata, want == 1 ? 8'ha5 : 8'h00, "read data");
        if (want == 1) check(rdata_valid, 1'b1, "read valid");
      end
    end
  endtask

  task automatic t_regs;
    logic [7:0] d;
    #1;
    check({bypass_active, cpu_clk_stop, refused, rdata_valid}, 4'h0, "reset outputs");
    reg_read(8'h00, d);
    check(d, 8'h00, "page select reset");
    reg_write(8'h00, 8'h83);
    reg_read(8'h00, d);
    check(d, 8'h83, "page select write");
    reg_write(8'h04, 8'h80);
    reg_write(8'h04, 8'h00);
    reg_read(8'h04, d);
    check(d, 8'h80, "sector mask sticks");
    reg_read(8'h40, d);
    check(d, 8'h00, "unmapped read");
    reg_write(8'h00, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_cpu;
    access(0, 2'b00, o_rd, 1'b0, 16'h0010, 1);
    access(0, 2'b00, o_pr, 1'b0, 16'h8000, 1);
    access(0, 2'b00, o_pe, 1'b0, 16'h0200, 1);
    access(0, 2'b11, o_me, 1'b0, 16'h0000, 0);
    access(0, 2'b11, o_pr, 1'b0, 16'he000, 0);
    access(0, 2'b11, o_pr, 1'b1, 16'h00c0, 2);
    access(0, 2'b11, o_pe, 1'b1, 16'h00c0, 2);
    $display("test cpu done");
  endtask

  // prot is {lower half, full}, both active low
  task automatic t_protect(input int src);
    for (int p = 0; p < 4; p++) begin
      access(src, p[1:0], o_rd, 1'b0, 16'h0100, p == 3);
      access(src, p[1:0], o_pr, 1'b0, 16'h8100, p[0]);
      access(src, p[1:0], o_me, 1'b0, 16'h0000, 1);
    end
    access(src, 2'b11, o_pe, 1'b0, 16'he000, 1);
    if (src == 1) begin
      access(1, 2'b11, o_pr, 1'b1, 16'h00c0, 2);
      reg_write(8'h00, 8'h83);
      access(1, 2'b11, o_pr, 1'b1, 16'h0080, 2);
      access(1, 2'b10, o_pe, 1'b1, 16'h00c0, 0);
      access(1, 2'b01, o_pr, 1'b1, 16'h00c0, 0);
      access(1, 2'b11, o_me, 1'b1, 16'h00c0, 0);
    end
    access(src, 2'b11, o_pr, 1'b1, 16'h00c0, 1);
    access(src, 2'b11, o_rd, 1'b1, 16'h00c0, 1);
    $display("test protect src %0d done", src);
  endtask

  task automatic t_bypass;
    prog.send3(8'h80, 8'hf0, 8'h05);
    repeat (4) @(posedge sys_clk);
    #1;
    check(bypass_active, 1'b0, "wrong entry byte");
    prog.send3(8'h80, 8'hf0, 8'h04);
    for (int i = 0; i < 3; i++) begin
      #1;
      // entry flop takes the data byte, outputs follow one edge later
      check({bypass_active, cpu_clk_stop}, i == 0 ? 2'b00 : 2'b11, "bypass entry");
      @(posedge sys_clk);
    end
    access(0, 2'b11, o_rd, 1'b0, 16'h0010, 2);
    t_protect(2);
    $display("test bypass done");
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    t_regs();
    t_cpu();
    t_protect(1);
    t_bypass();
    close_out();
  end
endmodule // test_flash_access_permission
`default_nettype wire
